// ==== pkg/irm_pkg.sv ====
package irm_pkg;

  // register byte offsets
  localparam logic [5:0] OFS_CONTROL_ONE     = 6'h00;
  localparam logic [5:0] OFS_CONTROL_TWO     = 6'h04;
  localparam logic [5:0] OFS_OWN_ADDRESS_ONE = 6'h08;
  localparam logic [5:0] OFS_OWN_ADDRESS_TWO = 6'h0C;
  localparam logic [5:0] OFS_DATA_BYTE       = 6'h10;
  localparam logic [5:0] OFS_STATUS_ONE      = 6'h14;
  localparam logic [5:0] OFS_STATUS_TWO      = 6'h18;
  localparam logic [5:0] OFS_BUS_CLOCK_CTRL  = 6'h1C;
  localparam logic [5:0] OFS_RISE_TIME_LIMIT = 6'h20;
  localparam logic [5:0] OFS_GLITCH_FILTER   = 6'h24;
  localparam logic [5:0] OFS_BYTE_COUNT      = 6'h28;

  // writable bit masks; registers hold 16 bits except the data byte, 8 bits, and status one, 13 bits
  localparam logic [15:0] MSK_CONTROL_ONE     = 16'h9FE1;
  localparam logic [15:0] MSK_CONTROL_TWO     = 16'h073F;
  localparam logic [15:0] MSK_OWN_ADDRESS_ONE = 16'h83FF;
  localparam logic [15:0] MSK_OWN_ADDRESS_TWO = 16'h00FF;
  localparam logic [15:0] MSK_DATA_BYTE       = 16'h00FF;
  localparam logic [15:0] MSK_BUS_CLOCK_CTRL  = 16'hCFFF;
  localparam logic [15:0] MSK_RISE_TIME_LIMIT = 16'h003F;
  localparam logic [15:0] MSK_GLITCH_FILTER   = 16'h3FFF;
  localparam logic [15:0] MSK_BYTE_COUNT      = 16'hFFFF;

  // reset values
  localparam logic [15:0] RST_ZERO            = 16'h0000;
  localparam logic [15:0] RST_RISE_TIME_LIMIT = 16'h0002;

  // control_one fields
  localparam int C1_ENABLE    = 0;
  localparam int C1_START_GEN = 8;
  localparam int C1_STOP_GEN  = 9;
  localparam int C1_ACK_EN    = 10;
  localparam int C1_ACK_POS   = 11;
  localparam int C1_PEC_XFER  = 12;

  // control_two fields
  localparam int C2_ERROR_IEN = 8;
  localparam int C2_EVENT_IEN = 9;
  localparam int C2_BUFFER_IEN = 10;

  // status_one fields
  localparam int S1_START_SENT = 0;
  localparam int S1_ADDR_DONE  = 1;
  localparam int S1_BYTE_DONE  = 2;
  localparam int S1_TEN_BIT    = 3;
  localparam int S1_STOP_SEEN  = 4;
  localparam int S1_RX_NEMPTY  = 6;
  localparam int S1_TX_EMPTY   = 7;
  localparam int S1_BUS_ERR    = 8;
  localparam int S1_ARB_LOST   = 9;
  localparam int S1_ACK_FAIL   = 10;
  localparam int S1_OVERRUN    = 11;
  localparam int S1_PEC_ERR    = 12;
  localparam int S1_WIDTH      = 13;
  localparam logic [12:0] S1_ERR_MASK = 13'h1F00;

  // status_two fields
  localparam int S2_CTRL_MODE = 0;
  localparam int S2_BUSY      = 1;
  localparam int S2_TRANSMIT  = 2;
  localparam int S2_GEN_CALL  = 4;
  localparam int S2_DUAL_HIT  = 7;
  localparam int S2_PEC_LSB   = 8;

endpackage

// ==== logic/irm_irq.sv ====
`timescale 1ns/1ps
module irm_irq (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // flags and enables
  input  wire logic [12:0] status_flags,
  input  wire logic        event_interrupt_enable,
  input  wire logic        buffer_interrupt_enable,
  input  wire logic        error_interrupt_enable,
  // request lines
  output logic             event_irq,
  output logic             error_irq
);

  logic plain_evt;
  logic buf_evt;
  logic any_err;

  // flags that need only the event enable
  assign plain_evt = status_flags[irm_pkg::S1_START_SENT]   // R1
                   | status_flags[irm_pkg::S1_ADDR_DONE]
                   | status_flags[irm_pkg::S1_TEN_BIT]
                   | status_flags[irm_pkg::S1_STOP_SEEN]
                   | status_flags[irm_pkg::S1_BYTE_DONE];
  // buffer flags also need the buffer enable
  assign buf_evt = buffer_interrupt_enable                   // R3
                 & (status_flags[irm_pkg::S1_RX_NEMPTY]
                 |  status_flags[irm_pkg::S1_TX_EMPTY]);
  assign any_err = |(status_flags & irm_pkg::S1_ERR_MASK);  // R5

  // registered levels, follow the flags with one cycle of lag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      event_irq <= 1'b0;
      error_irq <= 1'b0;
    end else begin
      event_irq <= event_interrupt_enable & (plain_evt | buf_evt); // R4 R8
      error_irq <= error_interrupt_enable & any_err;         // R5 R7 R8
    end
  end

endmodule

// ==== logic/irm_regs.sv ====
// Decided for this implementation: register access over APB.
`timescale 1ns/1ps
// How it works
// R1 - event line: events enabled and start, addr, header, stop or byte set.
// R2 - the address flag sets on a sent address or a matched own address.
// R3 - rx-not-empty and tx-empty need both event and buffer enables.
// R4 - all seven qualified event flags are ORed onto one event line.
// R5 - the five error flags are ORed onto an error line gated by its enable.
// R6 - halfword and word accesses give identical register behaviour.
// R7 - a mismatched acknowledge sets ack-failure, raising the error line.
// R8 - each line is a level: high while a qualified flag is set.
module irm_regs (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // event pulses from the serial engine
  input  wire logic        ev_start_sent,
  input  wire logic        ev_addr_sent,
  input  wire logic        ev_addr_match,
  input  wire logic        ev_ten_bit_sent,
  input  wire logic        ev_stop_seen,
  input  wire logic        ev_byte_done,
  input  wire logic        ev_rx_loaded,
  input  wire logic        ev_tx_taken,
  input  wire logic        ev_bus_error,
  input  wire logic        ev_arb_lost,
  input  wire logic        ev_ack_mismatch,
  input  wire logic        ev_overrun,
  input  wire logic        ev_pec_error,
  input  wire logic        ev_start_done,
  input  wire logic        ev_pec_done,
  // received byte and engine state
  input  wire logic [7:0]  rx_byte,
  input  wire logic        st_ctrl_mode,
  input  wire logic        st_busy,
  input  wire logic        st_transmit,
  input  wire logic        st_gen_call,
  input  wire logic        st_dual_hit,
  input  wire logic [7:0]  st_pec_value,
  // settings towards the serial engine
  output logic [15:0]      control_one,
  output logic [15:0]      control_two,
  output logic [15:0]      own_address_one,
  output logic [15:0]      own_address_two,
  output logic [7:0]       tx_byte,
  output logic [15:0]      bus_clock_control,
  output logic [15:0]      rise_time_limit,
  output logic [15:0]      glitch_filter_control,
  output logic [15:0]      byte_count_control,
  // interrupt lines
  output logic             event_irq,
  output logic             error_irq
);

  logic [15:0] ctrl1_q;
  logic [15:0] ctrl2_q;
  logic [15:0] oadr1_q;
  logic [15:0] oadr2_q;
  logic [7:0]  txb_q;
  logic [7:0]  rxb_q;
  logic [15:0] clk_q;
  logic [15:0] rise_q;
  logic [15:0] filt_q;
  logic [15:0] bcnt_q;
  logic [12:0] sts1_q;
  logic [12:0] sts1_d;
  logic        armed_q;
  logic        setup;
  logic        access;
  logic        wr;
  logic        rd;
  logic [5:0]  ofs;
  logic        mapped;
  logic [15:0] sts2_view;

  // merge byte lanes into a 16-bit register, keeping read-only bits
  function automatic logic [15:0] merge(input logic [15:0] old,
                                         input logic [31:0] wd,
                                         input logic [3:0]  st,
                                         input logic [15:0] msk);
    logic [15:0] nv;
    nv = old;
    if (st[0]) begin
      nv[7:0] = wd[7:0];
    end
    if (st[1]) begin
      nv[15:8] = wd[15:8];
    end
    merge = (nv & msk) | (old & ~msk);
  endfunction

  // upper lanes carry no bits, so a halfword and a word write match
  function automatic logic hit(input logic [5:0] a, input logic [5:0] r);
    hit = (a == r);
  endfunction

  // apb decode; access phase completes in one cycle
  assign setup  = psel & ~penable;
  assign access = psel & penable;
  assign ofs    = paddr[5:0];
  assign wr     = access & pwrite & ~pslverr;
  assign rd     = access & ~pwrite & ~pslverr;
  assign pready = 1'b1;
  assign mapped = (paddr[31:6] == 26'h0000000) && (ofs[1:0] == 2'b00)
                && (ofs <= irm_pkg::OFS_BYTE_COUNT);

  assign sts2_view = {st_pec_value, st_dual_hit, 2'b00, st_gen_call,
                      1'b0, st_transmit, st_busy, st_ctrl_mode};

  // read data and error are captured in setup, stable through access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end else if (setup) begin
      pslverr <= ~mapped;
      prdata  <= 32'h00000000;
      unique case (ofs)
        irm_pkg::OFS_CONTROL_ONE:     prdata[15:0] <= ctrl1_q;   // R6
        irm_pkg::OFS_CONTROL_TWO:     prdata[15:0] <= ctrl2_q;
        irm_pkg::OFS_OWN_ADDRESS_ONE: prdata[15:0] <= oadr1_q;
        irm_pkg::OFS_OWN_ADDRESS_TWO: prdata[15:0] <= oadr2_q;
        irm_pkg::OFS_DATA_BYTE:       prdata[7:0]  <= rxb_q;
        irm_pkg::OFS_STATUS_ONE:      prdata[12:0] <= sts1_q;
        irm_pkg::OFS_STATUS_TWO:      prdata[15:0] <= sts2_view;
        irm_pkg::OFS_BUS_CLOCK_CTRL:  prdata[15:0] <= clk_q;
        irm_pkg::OFS_RISE_TIME_LIMIT: prdata[15:0] <= rise_q;
        irm_pkg::OFS_GLITCH_FILTER:   prdata[15:0] <= filt_q;
        irm_pkg::OFS_BYTE_COUNT:      prdata[15:0] <= bcnt_q;
        default:                      prdata       <= 32'h00000000;
      endcase
    end
  end

  // control one: software writes, hardware clears the one-shot bits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl1_q <= irm_pkg::RST_ZERO;
    end else begin
      if (wr && hit(ofs, irm_pkg::OFS_CONTROL_ONE)) begin
        ctrl1_q <= merge(ctrl1_q, pwdata, pstrb, irm_pkg::MSK_CONTROL_ONE);
      end else begin
        if (ev_start_done) begin
          ctrl1_q[irm_pkg::C1_START_GEN] <= 1'b0;
        end
        if (ev_stop_seen) begin
          ctrl1_q[irm_pkg::C1_STOP_GEN] <= 1'b0;
        end
        if (ev_pec_done || ev_stop_seen || ev_start_done) begin
          ctrl1_q[irm_pkg::C1_PEC_XFER] <= 1'b0;
        end
        // disabling the block drops the per-transfer bits
        if (!ctrl1_q[irm_pkg::C1_ENABLE]) begin
          ctrl1_q[irm_pkg::C1_START_GEN] <= 1'b0;
          ctrl1_q[irm_pkg::C1_ACK_EN]    <= 1'b0;
          ctrl1_q[irm_pkg::C1_ACK_POS]   <= 1'b0;
          ctrl1_q[irm_pkg::C1_PEC_XFER]  <= 1'b0;
        end
      end
    end
  end

  // plain configuration registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl2_q <= irm_pkg::RST_ZERO;
      oadr1_q <= irm_pkg::RST_ZERO;
      oadr2_q <= irm_pkg::RST_ZERO;
      clk_q   <= irm_pkg::RST_ZERO;
      rise_q  <= irm_pkg::RST_RISE_TIME_LIMIT;
      filt_q  <= irm_pkg::RST_ZERO;
      bcnt_q  <= irm_pkg::RST_ZERO;
    end else if (wr) begin
      if (hit(ofs, irm_pkg::OFS_CONTROL_TWO)) begin
        ctrl2_q <= merge(ctrl2_q, pwdata, pstrb, irm_pkg::MSK_CONTROL_TWO);
      end
      if (hit(ofs, irm_pkg::OFS_OWN_ADDRESS_ONE)) begin
        oadr1_q <= merge(oadr1_q, pwdata, pstrb,
                         irm_pkg::MSK_OWN_ADDRESS_ONE);
      end
      if (hit(ofs, irm_pkg::OFS_OWN_ADDRESS_TWO)) begin
        oadr2_q <= merge(oadr2_q, pwdata, pstrb,
                         irm_pkg::MSK_OWN_ADDRESS_TWO);
      end
      if (hit(ofs, irm_pkg::OFS_BUS_CLOCK_CTRL)) begin
        clk_q <= merge(clk_q, pwdata, pstrb, irm_pkg::MSK_BUS_CLOCK_CTRL);
      end
      if (hit(ofs, irm_pkg::OFS_RISE_TIME_LIMIT)) begin
        rise_q <= merge(rise_q, pwdata, pstrb,
                        irm_pkg::MSK_RISE_TIME_LIMIT);
      end
      if (hit(ofs, irm_pkg::OFS_GLITCH_FILTER)) begin
        filt_q <= merge(filt_q, pwdata, pstrb, irm_pkg::MSK_GLITCH_FILTER);
      end
      if (hit(ofs, irm_pkg::OFS_BYTE_COUNT)) begin
        bcnt_q <= merge(bcnt_q, pwdata, pstrb, irm_pkg::MSK_BYTE_COUNT);
      end
    end
  end

  // data byte: transmit side written by software, receive side by engine
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      txb_q <= 8'h00;
      rxb_q <= 8'h00;
    end else begin
      if (wr && hit(ofs, irm_pkg::OFS_DATA_BYTE) && pstrb[0]) begin
        txb_q <= pwdata[7:0];
      end
      // an overrun keeps the unread byte, the new one is dropped
      if (ev_rx_loaded && !sts1_q[irm_pkg::S1_RX_NEMPTY]) begin
        rxb_q <= rx_byte;
      end
    end
  end

  // a status one read arms the two-step clears of the event flags
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      armed_q <= 1'b0;
    end else if (rd && hit(ofs, irm_pkg::OFS_STATUS_ONE)) begin
      armed_q <= 1'b1;
    end else if (access && !hit(ofs, irm_pkg::OFS_STATUS_ONE)) begin
      armed_q <= 1'b0;
    end
  end

  // status one next value: clears first, sets last so an event wins
  always_comb begin
    logic dat_wr;
    logic dat_rd;
    logic s2_rd;
    logic c1_wr;
    dat_wr = wr && hit(ofs, irm_pkg::OFS_DATA_BYTE);
    dat_rd = rd && hit(ofs, irm_pkg::OFS_DATA_BYTE);
    s2_rd  = rd && hit(ofs, irm_pkg::OFS_STATUS_TWO);
    c1_wr  = wr && hit(ofs, irm_pkg::OFS_CONTROL_ONE);
    sts1_d = sts1_q;
    if (armed_q && dat_wr) begin
      sts1_d[irm_pkg::S1_START_SENT] = 1'b0;
      sts1_d[irm_pkg::S1_TEN_BIT]    = 1'b0;
    end
    if (armed_q && s2_rd) begin
      sts1_d[irm_pkg::S1_ADDR_DONE] = 1'b0;
    end
    if (armed_q && c1_wr) begin
      sts1_d[irm_pkg::S1_STOP_SEEN] = 1'b0;
    end
    if (armed_q && (dat_wr || dat_rd)) begin
      sts1_d[irm_pkg::S1_BYTE_DONE] = 1'b0;
    end
    if (dat_rd) begin
      sts1_d[irm_pkg::S1_RX_NEMPTY] = 1'b0;
    end
    if (dat_wr) begin
      sts1_d[irm_pkg::S1_TX_EMPTY] = 1'b0;
    end
    // error flags clear where software writes a zero
    if (wr && hit(ofs, irm_pkg::OFS_STATUS_ONE) && pstrb[1]) begin
      sts1_d = sts1_d & (~irm_pkg::S1_ERR_MASK | pwdata[12:0]);
    end
    if (ev_start_sent) begin
      sts1_d[irm_pkg::S1_START_SENT] = 1'b1;
    end
    if (ev_addr_sent || ev_addr_match) begin
      sts1_d[irm_pkg::S1_ADDR_DONE] = 1'b1;                  // R2
    end
    if (ev_ten_bit_sent) begin
      sts1_d[irm_pkg::S1_TEN_BIT] = 1'b1;
    end
    if (ev_stop_seen) begin
      sts1_d[irm_pkg::S1_STOP_SEEN] = 1'b1;
    end
    if (ev_byte_done) begin
      sts1_d[irm_pkg::S1_BYTE_DONE] = 1'b1;
    end
    if (ev_rx_loaded) begin
      sts1_d[irm_pkg::S1_RX_NEMPTY] = 1'b1;
    end
    if (ev_tx_taken) begin
      sts1_d[irm_pkg::S1_TX_EMPTY] = 1'b1;
    end
    if (ev_bus_error) begin
      sts1_d[irm_pkg::S1_BUS_ERR] = 1'b1;
    end
    if (ev_arb_lost) begin
      sts1_d[irm_pkg::S1_ARB_LOST] = 1'b1;
    end
    if (ev_ack_mismatch) begin
      sts1_d[irm_pkg::S1_ACK_FAIL] = 1'b1;                   // R7
    end
    if (ev_overrun) begin
      sts1_d[irm_pkg::S1_OVERRUN] = 1'b1;
    end
    if (ev_pec_error) begin
      sts1_d[irm_pkg::S1_PEC_ERR] = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sts1_q <= 13'h0000;
    end else begin
      sts1_q <= sts1_d;
    end
  end

  // two request lines, gated by the control two enables
  irm_irq u_irq (
    .pclk                    (pclk),
    .presetn                 (presetn),
    .status_flags            (sts1_q),
    .event_interrupt_enable  (ctrl2_q[irm_pkg::C2_EVENT_IEN]),
    .buffer_interrupt_enable (ctrl2_q[irm_pkg::C2_BUFFER_IEN]),
    .error_interrupt_enable  (ctrl2_q[irm_pkg::C2_ERROR_IEN]),
    .event_irq               (event_irq),
    .error_irq               (error_irq)
  );

  // settings out to the engine
  assign control_one           = ctrl1_q;
  assign control_two           = ctrl2_q;
  assign own_address_one       = oadr1_q;
  assign own_address_two       = oadr2_q;
  assign tx_byte               = txb_q;
  assign bus_clock_control     = clk_q;
  assign rise_time_limit       = rise_q;
  assign glitch_filter_control = filt_q;
  assign byte_count_control    = bcnt_q;

endmodule

// ==== sim/irm_regs_monitor.sv ====
`timescale 1ns/1ps
module irm_regs_monitor (
  // clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // apb controls
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  // event pulses
  input wire logic        ev_start_sent,
  input wire logic        ev_addr_sent,
  input wire logic        ev_addr_match,
  input wire logic        ev_rx_loaded,
  input wire logic        ev_tx_taken,
  input wire logic        ev_bus_error,
  input wire logic        ev_arb_lost,
  input wire logic        ev_ack_mismatch,
  input wire logic        ev_overrun,
  input wire logic        ev_pec_error,
  // enables and lines
  input wire logic [15:0] control_two,
  input wire logic        event_irq,
  input wire logic        error_irq
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // enable bits pulled out once
  logic en_ev;
  logic en_er;
  logic en_bf;
  logic wr_acc;
  assign en_ev  = control_two[irm_pkg::C2_EVENT_IEN];
  assign en_er  = control_two[irm_pkg::C2_ERROR_IEN];
  assign en_bf  = control_two[irm_pkg::C2_BUFFER_IEN];
  assign wr_acc = psel && penable && pwrite;
  // pulse, then flag, then line: two edges in all
  chk_start_raise: assert property (
    ev_start_sent && en_ev ##1 en_ev |=> event_irq)
    else $error("event line missed a start flag");
  chk_addr_either: assert property (
    (ev_addr_sent || ev_addr_match) && en_ev ##1 en_ev |=> event_irq)
    else $error("event line missed an address flag");
  chk_buffer_both: assert property (
    ev_tx_taken && en_ev && en_bf ##1 en_ev && en_bf |=> event_irq)
    else $error("event line missed a buffer flag");
  chk_event_gate: assert property (event_irq |-> $past(en_ev))
    else $error("event line high while disabled");
  chk_error_any: assert property (
    (ev_bus_error || ev_arb_lost || ev_overrun || ev_pec_error) && en_er
    ##1 en_er |=> error_irq)
    else $error("error line missed an error flag");
  chk_error_gate: assert property (error_irq |-> $past(en_er))
    else $error("error line high while disabled");
  chk_ack_fail: assert property (
    ev_ack_mismatch && en_er ##1 en_er |=> error_irq)
    else $error("error line missed an ack failure");
  // error bits only clear by a write, so without one the level holds
  chk_error_hold: assert property (
    error_irq && en_er && !$past(wr_acc) |=> error_irq)
    else $error("error line dropped with flags still set");
  cover property (event_irq && error_irq);
  cover property ($fell(error_irq));
  cover property (ev_rx_loaded && en_ev && !en_bf);
endmodule
bind irm_regs irm_regs_monitor u_mon (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .ev_start_sent(ev_start_sent),
  .ev_addr_sent(ev_addr_sent), .ev_addr_match(ev_addr_match),
  .ev_rx_loaded(ev_rx_loaded), .ev_tx_taken(ev_tx_taken),
  .ev_bus_error(ev_bus_error), .ev_arb_lost(ev_arb_lost),
  .ev_ack_mismatch(ev_ack_mismatch), .ev_overrun(ev_overrun),
  .ev_pec_error(ev_pec_error), .control_two(control_two),
  .event_irq(event_irq), .error_irq(error_irq));

// ==== sim/irm_intc_model.sv ====
`timescale 1ns/1ps
module irm_intc_model (
  // clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // request lines
  input wire logic        event_irq,
  input wire logic        error_irq,
  // latched requests, bit 1 error
  output logic      [1:0] pending
);
  // sticky capture: a short glitch on a line is still seen by software
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pending <= 2'h0;
    end else begin
      pending <= pending | {error_irq, event_irq};
    end
  end
endmodule

// ==== sim/test_irm_regs.sv ====
`timescale 1ns/1ps
module test_irm_regs;
  // one row: pulse index, control_two, expected lines and status_one
  typedef struct packed {
    logic [3:0]  b;
    logic [15:0] en;
    logic        ei;
    logic        er;
    logic [15:0] sts;
  } irm_row_t;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [31:0] paddr;
  logic [31:0] pwdata;
  logic [3:0]  pstrb;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [14:0] ev;
  logic [7:0]  rx_byte;
  logic [4:0]  st;
  logic [7:0]  st_pec;
  logic        event_irq;
  logic        error_irq;
  logic [1:0]  pending;
  logic [15:0] cfg [8];
  logic [7:0]  txb;
  logic [31:0] rd;
  logic        err;
  int          error_cnt;
  int          comparisons;
  irm_row_t    rows [17] = '{
    '{4'h0, 16'h0200, 1'b1, 1'b0, 16'h0001},
    '{4'h1, 16'h0200, 1'b1, 1'b0, 16'h0002},
    '{4'h2, 16'h0200, 1'b1, 1'b0, 16'h0002},
    '{4'h3, 16'h0200, 1'b1, 1'b0, 16'h0008},
    '{4'h4, 16'h0200, 1'b1, 1'b0, 16'h0010},
    '{4'h5, 16'h0200, 1'b1, 1'b0, 16'h0004},
    '{4'h6, 16'h0600, 1'b1, 1'b0, 16'h0040},
    '{4'h6, 16'h0200, 1'b0, 1'b0, 16'h0040},
    '{4'h7, 16'h0600, 1'b1, 1'b0, 16'h0080},
    '{4'h7, 16'h0400, 1'b0, 1'b0, 16'h0080},
    '{4'h8, 16'h0100, 1'b0, 1'b1, 16'h0100},
    '{4'h9, 16'h0100, 1'b0, 1'b1, 16'h0200},
    '{4'hA, 16'h0100, 1'b0, 1'b1, 16'h0400},
    '{4'hB, 16'h0100, 1'b0, 1'b1, 16'h0800},
    '{4'hC, 16'h0100, 1'b0, 1'b1, 16'h1000},
    '{4'h0, 16'h0000, 1'b0, 1'b0, 16'h0001},
    '{4'h8, 16'h0600, 1'b0, 1'b0, 16'h0100}};

  irm_regs uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ev_start_sent(ev[0]), .ev_addr_sent(ev[1]), .ev_addr_match(ev[2]),
    .ev_ten_bit_sent(ev[3]), .ev_stop_seen(ev[4]), .ev_byte_done(ev[5]),
    .ev_rx_loaded(ev[6]), .ev_tx_taken(ev[7]), .ev_bus_error(ev[8]),
    .ev_arb_lost(ev[9]), .ev_ack_mismatch(ev[10]), .ev_overrun(ev[11]),
    .ev_pec_error(ev[12]), .ev_start_done(ev[13]), .ev_pec_done(ev[14]),
    .rx_byte(rx_byte), .st_ctrl_mode(st[0]), .st_busy(st[1]),
    .st_transmit(st[2]), .st_gen_call(st[3]), .st_dual_hit(st[4]),
    .st_pec_value(st_pec), .control_one(cfg[0]), .control_two(cfg[1]),
    .own_address_one(cfg[2]), .own_address_two(cfg[3]), .tx_byte(txb),
    .bus_clock_control(cfg[4]), .rise_time_limit(cfg[5]),
    .glitch_filter_control(cfg[6]), .byte_count_control(cfg[7]),
    .event_irq(event_irq), .error_irq(error_irq));

  irm_intc_model u_intc (.pclk(pclk), .presetn(presetn),
    .event_irq(event_irq), .error_irq(error_irq), .pending(pending));

  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // one apb transfer; the request stands until pready is sampled high
  task apb(input logic w, input logic [31:0] a, input logic [31:0] d,
           input logic [3:0] s);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task pulse(input int b);
    @(posedge pclk);
    ev <= 15'h1 << b;
    @(posedge pclk);
    ev <= 15'h0;
  endtask

  task do_reset;
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
  endtask

  task test_done;
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // cut a hang short; the whole run needs well under 2000 cycles
  initial begin
    repeat (5000) @(posedge pclk);
    error_cnt++;
    test_done();
  end

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 32'h0;
    pwdata = 32'h0;
    pstrb = 4'h0;
    ev = 15'h0;
    rx_byte = 8'h5A;
    st = 5'h15;
    st_pec = 8'h3C;
    error_cnt = 0;
    comparisons = 0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    // odd rows enable through a halfword write
    for (int i = 0; i < 17; i++) begin
      do_reset();
      apb(1'b1, 32'h4, {16'h0, rows[i].en}, i[0] ? 4'h3 : 4'hF);
      pulse(rows[i].b);
      repeat (3) @(posedge pclk);
      chk("event_irq", {31'h0, rows[i].ei}, {31'h0, event_irq});
      chk("error_irq", {31'h0, rows[i].er}, {31'h0, error_irq});
      chk("pending", {30'h0, rows[i].er, rows[i].ei}, {30'h0, pending});
      apb(1'b0, 32'h14, 32'h0, 4'hF);
      chk("status_one", {16'h0, rows[i].sts}, rd);
    end
    $display("row tests done");
    do_reset();
    apb(1'b0, 32'h20, 32'h0, 4'hF);
    chk("rise_time_limit", 32'h0000_0002, rd);
    apb(1'b0, 32'h0, 32'h0, 4'hF);
    chk("control_one", 32'h0, rd);
    chk("rise_time_limit out", 32'h0000_0002, {16'h0, cfg[5]});
    apb(1'b1, 32'h8, 32'hFFFF_FFFF, 4'hF);
    apb(1'b1, 32'h8, 32'h0, 4'hC);
    apb(1'b0, 32'h8, 32'h0, 4'h3);
    chk("own_address_one", 32'h0000_83FF, rd);
    chk("own_address_one out", 32'h0000_83FF, {16'h0, cfg[2]});
    apb(1'b1, 32'hC, 32'hFFFF_FFFF, 4'hF);
    apb(1'b1, 32'h1C, 32'hFFFF_FFFF, 4'hF);
    apb(1'b1, 32'h24, 32'hFFFF_FFFF, 4'hF);
    apb(1'b1, 32'h28, 32'hFFFF_FFFF, 4'h3);
    apb(1'b0, 32'h2C, 32'h0, 4'hF);
    chk("unmapped error", 32'h1, {31'h0, err});
    chk("unmapped data", 32'h0, rd);
    chk("own_address_two", {16'h0, irm_pkg::MSK_OWN_ADDRESS_TWO},
        {16'h0, cfg[3]});
    chk("bus_clock_control", {16'h0, irm_pkg::MSK_BUS_CLOCK_CTRL},
        {16'h0, cfg[4]});
    chk("glitch_filter", {16'h0, irm_pkg::MSK_GLITCH_FILTER},
        {16'h0, cfg[6]});
    chk("byte_count", {16'h0, irm_pkg::MSK_BYTE_COUNT},
        {16'h0, cfg[7]});
    // the engine's start-done pulse drops the start request bit
    apb(1'b1, 32'h0, 32'h0000_0101, 4'h3);
    pulse(13);
    @(posedge pclk);
    chk("start gen cleared", 32'h0000_0001, {16'h0, cfg[0]});
    apb(1'b0, 32'h18, 32'h0, 4'hF);
    chk("status_two", 32'h0000_3C85, rd);
    $display("register tests done");
    // error level follows its enable and clears with the flag
    apb(1'b1, 32'h4, 32'h0100, 4'hF);
    pulse(10);
    repeat (3) @(posedge pclk);
    chk("ack fail line", 32'h1, {31'h0, error_irq});
    apb(1'b1, 32'h4, 32'h0, 4'h3);
    repeat (2) @(posedge pclk);
    chk("error disabled", 32'h0, {31'h0, error_irq});
    apb(1'b1, 32'h4, 32'h0100, 4'h3);
    repeat (2) @(posedge pclk);
    chk("error enabled", 32'h1, {31'h0, error_irq});
    apb(1'b1, 32'h14, 32'h0, 4'h3);
    repeat (2) @(posedge pclk);
    chk("error cleared", 32'h0, {31'h0, error_irq});
    $display("error level test done");
    // two buffer flags: the line holds until the second one goes
    do_reset();
    apb(1'b1, 32'h4, 32'h0600, 4'hF);
    pulse(6);
    pulse(7);
    repeat (3) @(posedge pclk);
    chk("both buffer flags", 32'h1, {31'h0, event_irq});
    chk("control_two out", 32'h0000_0600, {16'h0, cfg[1]});
    apb(1'b0, 32'h10, 32'h0, 4'hF);
    chk("rx byte", 32'h0000_005A, rd);
    repeat (2) @(posedge pclk);
    chk("tx flag holds", 32'h1, {31'h0, event_irq});
    apb(1'b1, 32'h10, 32'h11, 4'hF);
    repeat (2) @(posedge pclk);
    chk("buffer flags gone", 32'h0, {31'h0, event_irq});
    chk("tx_byte out", 32'h0000_0011, {24'h0, txb});
    apb(1'b0, 32'h14, 32'h0, 4'hF);
    chk("status_one empty", 32'h0, rd);
    $display("buffer test done");
    // address flag: a status one read, then a status two read clears it
    pulse(1);
    apb(1'b0, 32'h14, 32'h0, 4'hF);
    chk("address flag", 32'h0000_0002, rd);
    apb(1'b0, 32'h18, 32'h0, 4'hF);
    repeat (2) @(posedge pclk);
    chk("address cleared", 32'h0, {31'h0, event_irq});
    apb(1'b0, 32'h14, 32'h0, 4'hF);
    chk("status_one after clear", 32'h0, rd);
    $display("clear test done");
    test_done();
  end
endmodule
